// >>> logic/pmms_pkg.sv
package pmms_pkg;
  localparam int unsigned ENTRIES  = 32;
  localparam int unsigned IDX_W    = 5;
  localparam int unsigned ENTRY_W  = 9;
  localparam int unsigned PAGE_W   = 7;
  localparam int unsigned OFFS_W   = 11;
  localparam int unsigned LADDR_W  = 16;
  localparam int unsigned PADDR_W  = 18;
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned ADR_W    = 8;

  // Word offsets on the register bus
  localparam logic [7:0] OFS_MODE     = 8'h00;
  localparam logic [7:0] OFS_PG_WR    = 8'h04;
  localparam logic [7:0] OFS_PG_RD    = 8'h08;
  localparam logic [7:0] OFS_CHK_ADDR = 8'h0C;
  localparam logic [7:0] OFS_CHK_STAT = 8'h10;

  // Operand and status field positions
  localparam int unsigned SEL_BIT     = 10;
  localparam int unsigned IDX_LSB     = 11;
  localparam int unsigned RO_BIT      = 7;
  localparam int unsigned ST_SET_BIT  = 13;
  localparam int unsigned ST_MODE_BIT = 14;
  localparam int unsigned ST_ERR_BIT  = 15;
  localparam int unsigned PAR_BIT     = 5;
  localparam int unsigned PROT_BIT    = 6;
  localparam int unsigned FIT_BIT     = 7;
  localparam int unsigned SYN_LSB     = 8;
  localparam int unsigned SEC_BIT     = 15;

  typedef enum logic [1:0] {
    PMMS_ABS = 2'h0,
    PMMS_PM0 = 2'h1,
    PMMS_PM1 = 2'h2
  } pmms_mode_t;

  typedef enum logic {
    PMMS_WB_IDLE = 1'h0,
    PMMS_WB_ACK  = 1'h1
  } pmms_wb_st_t;

  localparam pmms_mode_t         MODE_RST    = PMMS_ABS;
  localparam logic [WORD_W-1:0]  WORD_RST    = 16'h0000;
  localparam logic [PADDR_W-1:0] PADDR_RST   = 18'h00000;

  typedef struct packed {
    logic               req;
    logic               we;
    logic [LADDR_W-1:0] laddr;
  } pmms_mref_t;

  typedef struct packed {
    logic [4:0] check;
    logic       parity;
    logic       protect;
    logic [4:0] synd;
  } pmms_chk_t;
endpackage

// >>> logic/pmms_page_file.sv
module pmms_page_file #(
  parameter int unsigned DEPTH   = 32,
  parameter int unsigned IDX_W   = 5,
  parameter int unsigned WIDTH   = 9,
  parameter int unsigned NRD     = 3
) (
  input  wire logic                 clk_i,
  input  wire logic                 we_i,
  input  wire logic [IDX_W-1:0]     widx_i,
  input  wire logic [WIDTH-1:0]     wdata_i,
  input  wire logic [NRD*IDX_W-1:0] ridx_i,
  output logic      [NRD*WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  // Entries hold no reset; software loads them before paging is enabled
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[widx_i] <= wdata_i;
    end
  end

  for (genvar g = 0; g < NRD; g++) begin : g_rd
    assign rdata_o[g*WIDTH +: WIDTH] = mem_q[ridx_i[g*IDX_W +: IDX_W]];
  end
endmodule // pmms_page_file

// >>> logic/pmms_top.sv
// Functional notes
// - Select clear writes entry into file zero.
// - Select set writes entry into file one.
// - Entry page forms top seven address bits.
// - Entry bit seven marks page read-only.
// - Page write clears read-only error.
// - Page read returns page and flag.
// - Page read bits eight to twelve zero.
// - Page read bit thirteen shows set.
// - Page read bit fourteen shows paging.
// - Page read shows, then clears, error.
// - Check address translated per current mode.
// - Check bits, parity, protect returned low.
// - Bit seven shows correction fitted.
// - Syndrome in bits eight to twelve.
// - Fitted correction sets sticky single flag.
// - Unfitted correction reports parity error.
// - Status read clears single-error flag.
// - Absolute mode reaches lowest 65536 words.
// - Paging splits space into 2048-word segments.
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
module pmms_top #(
  parameter bit ECC_FITTED = 1'b1
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         cyc_i,
  input  wire logic                         stb_i,
  input  wire logic                         we_i,
  input  wire logic [pmms_pkg::ADR_W-1:0]   adr_i,
  input  wire logic [3:0]                   sel_i,
  input  wire logic [31:0]                  dat_i,
  output logic      [31:0]                  dat_o,
  output logic                              ack_o,
  input  wire pmms_pkg::pmms_mref_t         mref_i,
  output logic                              mem_req_o,
  output logic                              mem_we_o,
  output logic      [pmms_pkg::PADDR_W-1:0] mem_paddr_o,
  output logic      [pmms_pkg::PADDR_W-1:0] chk_paddr_o,
  input  wire pmms_pkg::pmms_chk_t          chk_i,
  input  wire logic                         sec_event_i,
  output logic                              parity_err_o,
  output logic                              ro_irq_o
);
  localparam int unsigned IW = pmms_pkg::IDX_W;
  localparam int unsigned EW = pmms_pkg::ENTRY_W;

  pmms_pkg::pmms_wb_st_t       st_q, st_d;
  logic [pmms_pkg::WORD_W-1:0] rdat_q, rdat_d;
  logic                        rep_ro_q, rep_ro_d;
  logic                        rep_sec_q, rep_sec_d;
  pmms_pkg::pmms_mode_t        mode_q, mode_d;
  logic [pmms_pkg::WORD_W-1:0] pg_rd_q, pg_rd_d;
  logic [pmms_pkg::WORD_W-1:0] chk_addr_q, chk_addr_d;
  logic                        ro_err_q, ro_err_d;
  logic                        sec_q, sec_d;
  logic                        par_q, par_d;
  logic                        mreq_q, mreq_d;
  logic                        mwe_q, mwe_d;
  logic [pmms_pkg::PADDR_W-1:0] mpa_q, mpa_d;

  logic [31:0]                 wdat;
  logic                        take, acc_wr, acc_rd;
  logic                        pg_wr, viol, paging;
  logic [3*IW-1:0]             ridx;
  logic [3*EW-1:0]             rd0, rd1;
  logic [EW-1:0]               ent_m, ent_c, ent_p;

  function automatic logic [pmms_pkg::PADDR_W-1:0] xlate(
    input pmms_pkg::pmms_mode_t       m,
    input logic [pmms_pkg::LADDR_W-1:0] la,
    input logic [EW-1:0]              ent
  );
    logic [pmms_pkg::PADDR_W-1:0] pa;
    pa = {2'h0, la};
    if (m != pmms_pkg::PMMS_ABS) begin
      pa = {ent[pmms_pkg::PAGE_W-1:0], la[pmms_pkg::OFFS_W-1:0]};
    end
    return pa;
  endfunction

  // Byte lanes not strobed read as zero in the operand
  assign wdat = dat_i & {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  assign take   = cyc_i && stb_i && (st_q == pmms_pkg::PMMS_WB_IDLE);
  assign acc_wr = cyc_i && stb_i && (st_q == pmms_pkg::PMMS_WB_ACK) && we_i;
  assign acc_rd = cyc_i && stb_i && (st_q == pmms_pkg::PMMS_WB_ACK) && !we_i;
  assign pg_wr  = acc_wr && (adr_i == pmms_pkg::OFS_PG_WR);
  assign paging = (mode_q != pmms_pkg::PMMS_ABS);

  // Port 0 maps references, 1 maps check address, 2 reads back
  assign ridx = {pg_rd_q[pmms_pkg::IDX_LSB +: IW],
                 chk_addr_q[pmms_pkg::IDX_LSB +: IW],
                 mref_i.laddr[pmms_pkg::IDX_LSB +: IW]};

  pmms_page_file #(
    .DEPTH   (pmms_pkg::ENTRIES),
    .IDX_W   (IW),
    .WIDTH   (EW),
    .NRD     (3)
  ) u_file0 (
    .clk_i   (clk_i),
    .we_i    (pg_wr && !wdat[pmms_pkg::SEL_BIT]),
    .widx_i  (wdat[pmms_pkg::IDX_LSB +: IW]),
    .wdata_i (wdat[EW-1:0]),
    .ridx_i  (ridx),
    .rdata_o (rd0)
  );

  pmms_page_file #(
    .DEPTH   (pmms_pkg::ENTRIES),
    .IDX_W   (IW),
    .WIDTH   (EW),
    .NRD     (3)
  ) u_file1 (
    .clk_i   (clk_i),
    .we_i    (pg_wr && wdat[pmms_pkg::SEL_BIT]),
    .widx_i  (wdat[pmms_pkg::IDX_LSB +: IW]),
    .wdata_i (wdat[EW-1:0]),
    .ridx_i  (ridx),
    .rdata_o (rd1)
  );

  assign ent_m = (mode_q == pmms_pkg::PMMS_PM1) ? rd1[0 +: EW] : rd0[0 +: EW];
  assign ent_c = (mode_q == pmms_pkg::PMMS_PM1) ? rd1[EW +: EW] : rd0[EW +: EW];
  assign ent_p = pg_rd_q[pmms_pkg::SEL_BIT] ? rd1[2*EW +: EW] : rd0[2*EW +: EW];

  assign viol = mref_i.req && mref_i.we && paging && ent_m[pmms_pkg::RO_BIT];

  assign chk_paddr_o = xlate(mode_q, chk_addr_q, ent_c);

  // Bus slave and command registers
  always_comb begin
    st_d       = st_q;
    rdat_d     = rdat_q;
    rep_ro_d   = rep_ro_q;
    rep_sec_d  = rep_sec_q;
    mode_d     = mode_q;
    pg_rd_d    = pg_rd_q;
    chk_addr_d = chk_addr_q;
    if (take) begin
      st_d      = pmms_pkg::PMMS_WB_ACK;
      rdat_d    = pmms_pkg::WORD_RST;
      rep_ro_d  = 1'b0;
      rep_sec_d = 1'b0;
      case (adr_i)
        pmms_pkg::OFS_MODE:     rdat_d = {14'h0000, mode_q};
        pmms_pkg::OFS_PG_RD: begin
          rdat_d   = {ro_err_q, paging, mode_q == pmms_pkg::PMMS_PM1, 5'h00, ent_p[7:0]};
          rep_ro_d = ro_err_q;
        end
        pmms_pkg::OFS_CHK_ADDR: rdat_d = chk_addr_q;
        pmms_pkg::OFS_CHK_STAT: begin
          rdat_d    = {sec_q, 2'h0, chk_i.synd, ECC_FITTED, chk_i.protect, chk_i.parity, chk_i.check};
          rep_sec_d = sec_q;
        end
        default:                rdat_d = pmms_pkg::WORD_RST;
      endcase
    end else if (st_q == pmms_pkg::PMMS_WB_ACK) begin
      st_d = pmms_pkg::PMMS_WB_IDLE;
    end
    if (acc_wr) begin
      case (adr_i)
        pmms_pkg::OFS_MODE: begin
          // Code three is not a mode; keep the previous one
          if (wdat[1:0] != 2'h3) begin
            mode_d = pmms_pkg::pmms_mode_t'(wdat[1:0]);
          end
        end
        pmms_pkg::OFS_PG_RD:    pg_rd_d    = wdat[pmms_pkg::WORD_W-1:0];
        pmms_pkg::OFS_CHK_ADDR: chk_addr_d = wdat[pmms_pkg::WORD_W-1:0];
        default:                mode_d     = mode_q;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q       <= pmms_pkg::PMMS_WB_IDLE;
      rdat_q     <= pmms_pkg::WORD_RST;
      rep_ro_q   <= 1'b0;
      rep_sec_q  <= 1'b0;
      mode_q     <= pmms_pkg::MODE_RST;
      pg_rd_q    <= pmms_pkg::WORD_RST;
      chk_addr_q <= pmms_pkg::WORD_RST;
    end else begin
      st_q       <= st_d;
      rdat_q     <= rdat_d;
      rep_ro_q   <= rep_ro_d;
      rep_sec_q  <= rep_sec_d;
      mode_q     <= mode_d;
      pg_rd_q    <= pg_rd_d;
      chk_addr_q <= chk_addr_d;
    end
  end

  // Sticky flags, the parity pulse and the translated reference path
  always_comb begin
    // set beats clear; a read clears only a flag it reported, a page write clears the read-only error regardless
    ro_err_d = (ro_err_q && !pg_wr && !(acc_rd && (adr_i == pmms_pkg::OFS_PG_RD) && rep_ro_q)) || viol;
    sec_d    = (sec_q && !(acc_rd && (adr_i == pmms_pkg::OFS_CHK_STAT) && rep_sec_q))
               || (sec_event_i && ECC_FITTED);
    par_d    = sec_event_i && !ECC_FITTED;
    mreq_d   = mref_i.req;
    mwe_d    = mref_i.req && mref_i.we && !viol;
    mpa_d    = xlate(mode_q, mref_i.laddr, ent_m);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ro_err_q <= 1'b0;
      sec_q    <= 1'b0;
      par_q    <= 1'b0;
      mreq_q   <= 1'b0;
      mwe_q    <= 1'b0;
      mpa_q    <= pmms_pkg::PADDR_RST;
    end else begin
      ro_err_q <= ro_err_d;
      sec_q    <= sec_d;
      par_q    <= par_d;
      mreq_q   <= mreq_d;
      mwe_q    <= mwe_d;
      mpa_q    <= mpa_d;
    end
  end

  assign ack_o        = (st_q == pmms_pkg::PMMS_WB_ACK);
  assign dat_o        = {16'h0000, rdat_q};
  assign mem_req_o    = mreq_q;
  assign mem_we_o     = mwe_q;
  assign mem_paddr_o  = mpa_q;
  assign parity_err_o = par_q;
  assign ro_irq_o     = ro_err_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ro_write;
    mref_i.req && mref_i.we && paging && ent_m[pmms_pkg::RO_BIT];
  endsequence

  sequence s_page_write;
    cyc_i && stb_i && ack_o && we_i && (adr_i == pmms_pkg::OFS_PG_WR);
  endsequence

  a_ro_write_blocked: assert property (s_ro_write |=> mem_req_o && !mem_we_o && ro_irq_o)
    else $error("read-only write not suppressed");
  a_ro_page_flag: assert property (mref_i.req && mref_i.we && paging && !ent_m[pmms_pkg::RO_BIT] |=> mem_we_o)
    else $error("writable page write dropped");
  a_page_wr_clears: assert property (s_page_write ##0 !viol |=> !ro_irq_o)
    else $error("page write left read-only error");
  a_abs_low_range: assert property (mref_i.req && !paging |=> mem_paddr_o[17:16] == 2'h0
                                    && mem_paddr_o[15:0] == $past(mref_i.laddr))
    else $error("absolute address out of low range");
  a_page_offset: assert property (mref_i.req && paging |=> mem_paddr_o[10:0] == $past(mref_i.laddr[10:0])
                                  && mem_paddr_o[17:11] == $past(ent_m[6:0]))
    else $error("paged address wrong");
  a_pg_rd_zeros: assert property (take && (adr_i == pmms_pkg::OFS_PG_RD) |=> ack_o && dat_o[12:8] == 5'h00
                                  && dat_o[14] == $past(paging))
    else $error("page read status bits wrong");
  a_pg_rd_clear: assert property (take && !we_i && (adr_i == pmms_pkg::OFS_PG_RD) && ro_err_q && !viol
                                  ##1 ack_o && cyc_i && stb_i && !viol |=> !ro_irq_o)
    else $error("page read did not clear error");
  a_chk_fitted: assert property (take && (adr_i == pmms_pkg::OFS_CHK_STAT) |=> dat_o[7] == ECC_FITTED
                                 && dat_o[12:8] == $past(chk_i.synd))
    else $error("check status fit bit or syndrome wrong");
  a_sec_sets: assert property (sec_event_i |=> (sec_q == ECC_FITTED) && (parity_err_o == !ECC_FITTED))
    else $error("single error report wrong");
  a_sec_clear: assert property (take && !we_i && (adr_i == pmms_pkg::OFS_CHK_STAT) && sec_q
                                ##1 ack_o && cyc_i && stb_i && !sec_event_i |=> !sec_q)
    else $error("status read did not clear single flag");
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held over two cycles");
  // Fixed single wait state
  a_take_acks: assert property (take |=> ack_o && (dat_o[31:16] == 16'h0000))
    else $error("request not answered in next cycle");
  a_ro_err_sticky: assert property (ro_irq_o && !pg_wr && !(acc_rd && (adr_i == pmms_pkg::OFS_PG_RD))
                                    |=> ro_irq_o)
    else $error("read-only error lost without a clear");
  a_ro_irq_cause: assert property ($rose(ro_irq_o) |-> $past(viol))
    else $error("read-only error raised without a violation");
  a_sec_sticky: assert property (sec_q && !(acc_rd && (adr_i == pmms_pkg::OFS_CHK_STAT)) |=> sec_q)
    else $error("single-error flag lost without a clear");
  a_par_pulse: assert property (parity_err_o |-> $past(sec_event_i) && !ECC_FITTED)
    else $error("parity error without a single-bit event");
  // Reserved mode code must not disturb paging
  a_mode_three_kept: assert property (acc_wr && (adr_i == pmms_pkg::OFS_MODE) && (wdat[1:0] == 2'h3)
                                      |=> $stable(mode_q))
    else $error("reserved mode code changed the mode");
endmodule // pmms_top

// >>> verification/pmms_mem_model.sv
module pmms_mem_model (
  input  wire logic [pmms_pkg::PADDR_W-1:0] paddr_i,
  output pmms_pkg::pmms_chk_t               chk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // per-word status
  // Derived from the address so a wrong translation shows up
  assign chk_o = '{check: paddr_i[4:0] ^ paddr_i[17:13], parity: ^paddr_i,
                   protect: paddr_i[11], synd: paddr_i[9:5]};
endmodule // pmms_mem_model

// >>> verification/tb_page_map_and_memory_status.sv
module tb_page_map_and_memory_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_i = 1'h0;
  logic                 rst_i = 1'h1;
  logic                 cyc_i = 1'h0;
  logic                 stb_i = 1'h0;
  logic                 we_i = 1'h0;
  logic                 sec_event_i = 1'h0;
  logic [7:0]           adr_i = 8'h00;
  logic [3:0]           sel_i = 4'h0;
  logic [31:0]          dat_i = 32'h0;
  logic [31:0]          dat_o;
  logic [31:0]          rd;
  logic [31:0]          dat_nf;
  logic [31:0]          rd_nf;
  logic                 par_nf;
  logic                 ack_o;
  logic                 mem_req_o;
  logic                 mem_we_o;
  logic                 parity_err_o;
  logic                 ro_irq_o;
  logic [17:0]          mem_paddr_o;
  logic [17:0]          chk_paddr_o;
  pmms_pkg::pmms_mref_t mref_i = '0;
  pmms_pkg::pmms_chk_t  chk_i;
  logic [8:0]           ent [2][32];
  int                   n_fail = 0;
  int                   compares = 0;
  int                   cycles = 0;
  int                   seed = 38441;

  pmms_top #(.ECC_FITTED(1'h1)) uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .mref_i(mref_i),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_paddr_o(mem_paddr_o), .chk_paddr_o(chk_paddr_o),
    .chk_i(chk_i), .sec_event_i(sec_event_i), .parity_err_o(parity_err_o), .ro_irq_o(ro_irq_o));
  // Copy without correction hardware, to reach the parity path
  pmms_top #(.ECC_FITTED(1'h0)) uut_nf (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_nf), .ack_o(), .mref_i(mref_i),
    .mem_req_o(), .mem_we_o(), .mem_paddr_o(), .chk_paddr_o(),
    .chk_i(chk_i), .sec_event_i(sec_event_i), .parity_err_o(par_nf), .ro_irq_o());
  pmms_mem_model mem (.paddr_i(chk_paddr_o), .chk_o(chk_i));

  always #2 clk_i = ~clk_i;

  // Whole run needs well under this
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= {16'h0000, d};
    sel_i <= 4'hF;
    do @(posedge clk_i); while (ack_o !== 1'h1);
    rd = dat_o;
    rd_nf = dat_nf;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
  endtask

  function automatic logic [17:0] xl(input logic [1:0] m, input logic [15:0] a);
    logic [8:0] e;
    if (m == 2'h0)
      return {2'h0, a};
    e = ent[m[1]][a[15:11]];
    return {e[6:0], a[10:0]};
  endfunction

  function automatic logic [31:0] stat(input logic [17:0] p, input logic s, input logic fit);
    return {16'h0000, s, 2'h0, p[9:5], fit, p[11], ^p, p[4:0] ^ p[17:13]};
  endfunction

  initial begin
    int         f;
    int         i;
    int         k;
    logic       w;
    logic       roe;
    logic       sec;
    logic [1:0] mode;
    logic [8:0] e;
    logic [15:0] la;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    bus(1'h0, pmms_pkg::OFS_MODE, 16'h0000);
    chk("mode_rst", 32'h0, rd);
    for (k = 0; k < 4; k++) begin
      bus(1'h1, pmms_pkg::OFS_MODE, 16'(k));
      bus(1'h0, pmms_pkg::OFS_MODE, 16'h0000);
      chk("mode", (k == 3) ? 32'h2 : 32'(k), rd);
    end
    bus(1'h1, 8'h20, 16'hFFFF);
    bus(1'h0, 8'h20, 16'h0000);
    chk("unmapped", 32'h0, rd);
    $display("modes test done");
    // Operand bit 9 left zero by the issuing side
    // spare bit zero
    for (f = 0; f < 2; f++) begin
      for (i = 0; i < 32; i++) begin
        e = 9'($random(seed));
        ent[f][i] = e;
        bus(1'h1, pmms_pkg::OFS_PG_WR, {i[4:0], f[0], 1'h0, e});
      end
    end
    for (f = 0; f < 2; f++) begin
      bus(1'h1, pmms_pkg::OFS_MODE, {14'h0, f[0], ~f[0]});
      for (i = 0; i < 32; i++) begin
        bus(1'h1, pmms_pkg::OFS_PG_RD, {i[4:0], f[0], 10'h000});
        bus(1'h0, pmms_pkg::OFS_PG_RD, 16'h0000);
        chk("page_rd", {18'h00001, f[0], 5'h00, ent[f][i][7:0]}, rd);
      end
    end
    bus(1'h1, pmms_pkg::OFS_MODE, 16'h0000);
    bus(1'h0, pmms_pkg::OFS_PG_RD, 16'h0000);
    chk("abs_flag", 32'h0, rd & 32'h4000);
    $display("page file test done");
    roe = 1'h0;
    for (k = 0; k < 60; k++) begin
      mode = 2'(k % 3);
      la = 16'($random(seed));
      w = 1'($random(seed));
      bus(1'h1, pmms_pkg::OFS_MODE, {14'h0, mode});
      @(posedge clk_i);
      mref_i <= '{req: 1'h1, we: w, laddr: la};
      @(posedge clk_i);
      mref_i <= '0;
      @(negedge clk_i);
      roe = w && mode != 2'h0 && ent[mode[1]][la[15:11]][7];
      chk("mem_req", 32'h1, mem_req_o);
      chk("mem_paddr", xl(mode, la), mem_paddr_o);
      chk("mem_we", w & ~roe, mem_we_o);
      chk("ro_irq", roe, ro_irq_o);
      if (roe && k[0]) begin
        bus(1'h0, pmms_pkg::OFS_PG_RD, 16'h0000);
        chk("ro_bit", 32'h1, rd[15]);
        bus(1'h0, pmms_pkg::OFS_PG_RD, 16'h0000);
        chk("ro_bit_clr", 32'h0, rd[15]);
      end else if (roe) begin
        bus(1'h1, pmms_pkg::OFS_PG_WR, {la[15:11], mode[1], 1'h0, ent[mode[1]][la[15:11]]});
        @(negedge clk_i);
        chk("ro_clr_wr", 32'h0, ro_irq_o);
      end
    end
    $display("memory reference test done");
    for (k = 0; k < 12; k++) begin
      mode = 2'(k % 3);
      la = 16'($random(seed));
      sec = (k % 4) == 1;
      bus(1'h1, pmms_pkg::OFS_MODE, {14'h0, mode});
      bus(1'h1, pmms_pkg::OFS_CHK_ADDR, la);
      @(negedge clk_i);
      chk("chk_paddr", xl(mode, la), chk_paddr_o);
      if (sec) begin
        @(posedge clk_i);
        sec_event_i <= 1'h1;
        @(posedge clk_i);
        sec_event_i <= 1'h0;
        @(negedge clk_i);
        chk("par_err", 32'h0, parity_err_o);
        chk("par_err_nf", 32'h1, par_nf);
      end
      bus(1'h0, pmms_pkg::OFS_CHK_STAT, 16'h0000);
      chk("stat", stat(xl(mode, la), sec, 1'h1), rd);
      chk("stat_nf", stat(xl(mode, la), 1'h0, 1'h0), rd_nf);
      bus(1'h0, pmms_pkg::OFS_CHK_STAT, 16'h0000);
      chk("stat_clr", stat(xl(mode, la), 1'h0, 1'h1), rd);
    end
    $display("check status test done");
    report_and_stop();
  end
endmodule // tb_page_map_and_memory_status
